/* inc/tca_map.svh */
// Register offsets, reset values and timing counts of the conversion core.
// Assumes inclusion by bare name from core or bench files.
`ifndef TCA_MAP_SVH
`define TCA_MAP_SVH
`define TCA_CMD_CONVERT 8'h44
`define TCA_OFS_TEMP_LSB 4'h0
`define TCA_OFS_TEMP_MSB 4'h1
`define TCA_OFS_UPPER 4'h2
`define TCA_OFS_LOWER 4'h3
`define TCA_OFS_RES 4'h4
`define TCA_TEMP_RESET 16'h0550
`define TCA_RES_RESET 2'h3
`define TCA_UPPER_RESET 8'h7F
`define TCA_LOWER_RESET 8'h80
`define TCA_CONV_MS 750
`define TCA_CLK_KHZ 25000
`define TCA_CONV_CYCLES (`TCA_CONV_MS * `TCA_CLK_KHZ)
`endif

/* inc/tca_pkg.sv */
// Types of the conversion core.
// Assumes the map header carries all numbers.
package tca_pkg;
  typedef enum logic [1:0] {TCA_RES_9, TCA_RES_10, TCA_RES_11, TCA_RES_12} tca_res_e;
  typedef enum logic {TCA_IDLE, TCA_CONV} tca_state_e;
endpackage : tca_pkg

/* core/tca_core.sv */
// Temperature conversion, result register and alarm compare.
// Assumes a link layer on core_clk_i delivers decoded commands, scratchpad writes and read slots.
`timescale 1ns/1ps
`include "tca_map.svh"
// Functional notes
// - Resolutions 9 to 12 bits, steps 0.5 down to 0.0625 degrees.
// - Resolution is 12 bits after power-up until reconfigured.
// - Idle after power-up; conversion starts only on command 44h.
// - Finished conversion writes two-byte result, then returns to idle.
// - Externally powered: read slots answer 0 while converting, 1 when done.
// - Result is 16-bit sign-extended two's complement, four fraction bits.
// - Upper five result bits repeat the sign.
// - Low result bits undefined below 12-bit resolution (forced zero here).
// - Result holds 0550h (+85 degrees) until first conversion.
// - After each conversion compare against one-byte signed alarm limits.
// - Alarm limits held in nonvolatile storage (plain registers here, reset to 7Fh and 80h).
// - Upper limit at scratchpad byte 2, lower at byte 3.
// - Compare uses result bits 11..4; alarm when at or beyond limits.
// - Alarm flag recomputed after every conversion.
module tca_core #(
  parameter int unsigned CONV_CYCLES = `TCA_CONV_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic wr_en_i,
  input wire logic [3:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_slot_i,
  input wire logic [3:0] rd_addr_i,
  input wire logic ext_power_i,
  input wire logic sensor_valid_i,
  input wire logic [11:0] sensor_temp_i,
  output logic [7:0] rd_data_o,
  output logic slot_bit_o,
  output logic slot_valid_o,
  output logic busy_o,
  output logic alarm_o,
  output logic [15:0] temperature_result_o
);
  tca_pkg::tca_state_e state;
  tca_pkg::tca_res_e res_cfg;
  tca_pkg::tca_res_e res_run;
  logic [7:0] upper_alarm_limit;
  logic [7:0] lower_alarm_limit;
  logic [31:0] conv_cnt;
  logic [11:0] sens_s1;
  logic [11:0] sens_s2;
  logic sens_v1;
  logic sens_v2;
  logic conv_done;
  logic [11:0] masked;
  logic [15:0] next_temp;
  logic [7:0] cmp_val;

  // Sensor comes from the analog side, two flops before use
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      sens_s1 <= 12'h000;
      sens_s2 <= 12'h000;
      sens_v1 <= 1'b0;
      sens_v2 <= 1'b0;
    end
    else if (clk_en_i)
    begin
      sens_s1 <= sensor_temp_i;
      sens_s2 <= sens_s1;
      sens_v1 <= sensor_valid_i;
      sens_v2 <= sens_v1;
    end
  end

  always_comb
  begin
    masked = sens_s2;
    case (res_run)
      tca_pkg::TCA_RES_9: masked[2:0] = 3'h0;
      tca_pkg::TCA_RES_10: masked[1:0] = 2'h0;
      tca_pkg::TCA_RES_11: masked[0] = 1'b0;
      default: masked = sens_s2;
    endcase
    next_temp = {{4{masked[11]}}, masked};
    cmp_val = next_temp[11:4];
  end

  assign conv_done = (state == tca_pkg::TCA_CONV) && (conv_cnt == CONV_CYCLES - 1) && sens_v2;

  // Limits and resolution; limits stand in for EEPROM-backed values
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      upper_alarm_limit <= `TCA_UPPER_RESET;
      lower_alarm_limit <= `TCA_LOWER_RESET;
      res_cfg <= tca_pkg::tca_res_e'(`TCA_RES_RESET);
    end
    else if (clk_en_i && wr_en_i)
    begin
      case (wr_addr_i)
        `TCA_OFS_UPPER: upper_alarm_limit <= wr_data_i;
        `TCA_OFS_LOWER: lower_alarm_limit <= wr_data_i;
        `TCA_OFS_RES: res_cfg <= tca_pkg::tca_res_e'(wr_data_i[6:5]);
        default: ;
      endcase
    end
  end

  // Conversion sequencer
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      state <= tca_pkg::TCA_IDLE;
      conv_cnt <= 32'h0000_0000;
      res_run <= tca_pkg::TCA_RES_12;
      busy_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      case (state)
        tca_pkg::TCA_IDLE:
          if (cmd_valid_i && cmd_code_i == `TCA_CMD_CONVERT)
          begin
            state <= tca_pkg::TCA_CONV;
            res_run <= res_cfg;
            conv_cnt <= 32'h0000_0000;
            busy_o <= 1'b1;
          end
        tca_pkg::TCA_CONV:
          if (conv_done)
          begin
            state <= tca_pkg::TCA_IDLE;
            busy_o <= 1'b0;
          end
          else if (conv_cnt != CONV_CYCLES - 1)
            conv_cnt <= conv_cnt + 32'h0000_0001;
        default: state <= tca_pkg::TCA_IDLE;
      endcase
    end
  end

  // Result register and alarm flag
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      temperature_result_o <= `TCA_TEMP_RESET;
      alarm_o <= 1'b0;
    end
    else if (clk_en_i && conv_done)
    begin
      temperature_result_o <= next_temp;
      alarm_o <= ($signed(cmp_val) <= $signed(lower_alarm_limit))
        || ($signed(cmp_val) >= $signed(upper_alarm_limit));
    end
  end

  // Read slot answer and scratchpad reads
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      slot_bit_o <= 1'b1;
      slot_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
    end
    else if (clk_en_i)
    begin
      slot_valid_o <= rd_slot_i && ext_power_i;
      slot_bit_o <= !busy_o;
      case (rd_addr_i)
        `TCA_OFS_TEMP_LSB: rd_data_o <= temperature_result_o[7:0];
        `TCA_OFS_TEMP_MSB: rd_data_o <= temperature_result_o[15:8];
        `TCA_OFS_UPPER: rd_data_o <= upper_alarm_limit;
        `TCA_OFS_LOWER: rd_data_o <= lower_alarm_limit;
        `TCA_OFS_RES: rd_data_o <= {1'b0, res_cfg, 5'h1F};
        default: rd_data_o <= 8'h00;
      endcase
    end
  end

  chk_idle_needs_cmd: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    $rose(busy_o) |-> $past(cmd_valid_i) && $past(cmd_code_i) == `TCA_CMD_CONVERT)
    else $error("conversion began without convert command");
  chk_sign_ext: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    temperature_result_o[15:11] == {5{temperature_result_o[11]}})
    else $error("result sign not extended");
  chk_low_bits: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (clk_en_i && conv_done && res_run == tca_pkg::TCA_RES_9) |=> temperature_result_o[2:0] == 3'h0)
    else $error("9-bit result low bits not cleared");
  chk_reset_temp: assert property (@(posedge core_clk_i)
    !rst_b_i |=> temperature_result_o == `TCA_TEMP_RESET)
    else $error("result not 0550h after reset");
  chk_done_idle: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (clk_en_i && conv_done) |=> !busy_o && temperature_result_o == $past(next_temp))
    else $error("done did not store result and idle");
  chk_slot_busy: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (clk_en_i && rd_slot_i && ext_power_i) |=> slot_valid_o && slot_bit_o == !$past(busy_o))
    else $error("read slot answer wrong");
  chk_alarm_cmp: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (clk_en_i && conv_done && $signed(cmp_val) >= $signed(upper_alarm_limit)) |=> alarm_o)
    else $error("upper alarm missed");
  chk_alarm_clear: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (clk_en_i && conv_done && $signed(cmp_val) > $signed(lower_alarm_limit)
      && $signed(cmp_val) < $signed(upper_alarm_limit)) |=> !alarm_o)
    else $error("alarm not cleared");
  chk_res_sample: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    $rose(busy_o) |-> res_run == $past(res_cfg))
    else $error("resolution not sampled at start");
  chk_limit_write: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (clk_en_i && wr_en_i && wr_addr_i == `TCA_OFS_UPPER) |=> upper_alarm_limit == $past(wr_data_i))
    else $error("upper limit write lost");
endmodule : tca_core

/* verif/tca_sensor_model.sv */
// Sensor front end that presents a held sample to the core.
// Assumes the bench sets the level between conversions.
`timescale 1ns/1ps
module tca_sensor_model (
  input wire logic core_clk_i,
  input wire logic [11:0] level_i,
  input wire logic valid_i,
  output logic sensor_valid_o,
  output logic [11:0] sensor_temp_o
);
  always_ff @(posedge core_clk_i)
  begin
    sensor_valid_o <= valid_i;
    sensor_temp_o <= level_i;
  end
endmodule : tca_sensor_model

/* verif/temp_conversion_alarm_compare_tb_top.sv */
// Self-checking bench for the conversion core.
// Assumes the map header and a shortened conversion count.
`timescale 1ns/1ps
`include "tca_map.svh"
module temp_conversion_alarm_compare_tb_top;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic wr_en_i = 1'b0;
  logic rd_slot_i = 1'b0;
  logic ext_power_i = 1'b1;
  logic [7:0] cmd_code_i = 8'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic [3:0] wr_addr_i = 4'h0;
  logic [3:0] rd_addr_i = 4'h0;
  logic [11:0] level = 12'h000;
  logic clk_en = 1'b1;
  logic sens_ok = 1'b1;
  logic sensor_valid_i, slot_bit_o, slot_valid_o, busy_o, alarm_o;
  logic [11:0] sensor_temp_i;
  logic [7:0] rd_data_o;
  logic [15:0] temperature_result_o;
  int n_mismatch = 0;
  int tests_run = 0;
  always #20 core_clk_i = ~core_clk_i;
  tca_sensor_model model (.core_clk_i, .level_i(level), .valid_i(sens_ok), .sensor_valid_o(sensor_valid_i),
    .sensor_temp_o(sensor_temp_i));
  tca_core #(.CONV_CYCLES(8)) dut (.core_clk_i, .rst_b_i, .clk_en_i(clk_en), .cmd_valid_i, .cmd_code_i,
    .wr_en_i, .wr_addr_i, .wr_data_i, .rd_slot_i, .rd_addr_i, .ext_power_i, .sensor_valid_i,
    .sensor_temp_i, .rd_data_o, .slot_bit_o, .slot_valid_o, .busy_o, .alarm_o, .temperature_result_o);
  task automatic end_sim;
    $display("Mismatches %0d of %0d comparisons", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] c);
    @(posedge core_clk_i) cmd_valid_i <= 1'b1;
    cmd_code_i <= c;
    @(posedge core_clk_i) cmd_valid_i <= 1'b0;
  endtask : cmd
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i) wr_en_i <= 1'b1;
    wr_addr_i <= a;
    wr_data_i <= d;
    @(posedge core_clk_i) wr_en_i <= 1'b0;
  endtask : wr
  // Read slot: answer flag and byte seen one edge after the slot
  task automatic slot(input logic [3:0] a, input logic [7:0] d, input logic b);
    @(posedge core_clk_i) rd_slot_i <= 1'b1;
    rd_addr_i <= a;
    @(posedge core_clk_i) rd_slot_i <= 1'b0;
    #1 chk({15'h0000, slot_valid_o}, {15'h0000, ext_power_i});
    chk({15'h0000, slot_bit_o}, {15'h0000, b});
    chk({8'h00, rd_data_o}, {8'h00, d});
  endtask : slot
  task automatic conv(input logic [11:0] t, input logic [15:0] r, input logic al);
    int i;
    @(posedge core_clk_i) level <= t;
    cmd(`TCA_CMD_CONVERT);
    #1 chk({15'h0000, busy_o}, 16'h0001);
    if (ext_power_i === 1'b1)
      slot(4'hF, 8'h00, 1'b0);
    for (i = 0; i < 40 && busy_o !== 1'b0; i++)
      @(posedge core_clk_i) #1;
    chk(temperature_result_o, r);
    chk({15'h0000, alarm_o}, {15'h0000, al});
    if (i == 40)
    begin
      n_mismatch++;
      end_sim();
    end
  endtask : conv
  initial
  begin
    repeat (5) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    #1 chk(temperature_result_o, `TCA_TEMP_RESET);
    slot(4'h0, 8'h50, 1'b1);
    slot(4'h1, 8'h05, 1'b1);
    slot(4'h2, 8'h7F, 1'b1);
    slot(4'h3, 8'h80, 1'b1);
    slot(4'h4, 8'h7F, 1'b1);
    cmd(8'h4E);
    #1 chk({15'h0000, busy_o}, 16'h0000);
    conv(12'hF5E, 16'hFF5E, 1'b0);
    // Low enable holds a running conversion where it stands
    cmd(`TCA_CMD_CONVERT);
    clk_en <= 1'b0;
    repeat (20) @(posedge core_clk_i);
    #1 chk({15'h0000, busy_o}, 16'h0001);
    @(posedge core_clk_i) clk_en <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    #1 chk({15'h0000, busy_o}, 16'h0001);
    repeat (4) @(posedge core_clk_i);
    #1 chk({15'h0000, busy_o}, 16'h0000);
    chk(temperature_result_o, 16'hFF5E);
    // Completion waits for a valid sensor sample
    @(posedge core_clk_i) sens_ok <= 1'b0;
    cmd(`TCA_CMD_CONVERT);
    repeat (16) @(posedge core_clk_i);
    #1 chk({15'h0000, busy_o}, 16'h0001);
    @(posedge core_clk_i) sens_ok <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    #1 chk({15'h0000, busy_o}, 16'h0000);
    // Reset in mid-conversion restores the power-up state
    wr(4'h4, 8'h1F);
    cmd(`TCA_CMD_CONVERT);
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    #1 chk(temperature_result_o, `TCA_TEMP_RESET);
    chk({15'h0000, busy_o}, 16'h0000);
    slot(4'h4, 8'h7F, 1'b1);
    wr(4'h2, 8'h19);
    wr(4'h4, 8'h1F);
    conv(12'h191, 16'h0190, 1'b1);
    wr(4'h4, 8'h7F);
    wr(4'h3, 8'h0A);
    conv(12'h0A2, 16'h00A2, 1'b1);
    wr(4'h3, 8'h80);
    wr(4'h2, 8'h7F);
    // Bus-powered: no slots while the conversion runs
    @(posedge core_clk_i) ext_power_i <= 1'b0;
    conv(12'h008, 16'h0008, 1'b0);
    slot(4'hF, 8'h00, 1'b1);
    end_sim();
  end
endmodule : temp_conversion_alarm_compare_tb_top
